// file: design/ffr_top.sv
// FIFO status flags, offset registers and synchronous retransmit
`timescale 1ns/1ps
module ffr_top
  import ffr_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rstn,
  // Write port pins
  input  wire logic              write_port_clock,
  input  wire logic              write_side_select_n,
  input  wire logic              write_side_direction,
  input  wire logic              write_side_strobe,
  input  wire logic              write_side_mail_sel,
  input  wire logic [ffr_pkg::DW-1:0] write_data,
  // FIFO reset and offset loading pins
  input  wire logic              fifo_reset_n,
  input  wire logic [1:0]        offset_mode,
  input  wire logic              serial_offset_en_n,
  input  wire logic              serial_offset_bit,
  // Read port pins
  input  wire logic              read_port_clock,
  input  wire logic              read_side_select_n,
  input  wire logic              read_side_direction,
  input  wire logic              read_side_strobe,
  input  wire logic              read_side_mail_sel,
  input  wire logic              replay_mode_in,
  input  wire logic              replay_from_mark_in,
  // Flags and data
  output logic                   write_space_flag,
  output logic                   near_full_flag_n,
  output logic                   read_valid_flag,
  output logic                   near_empty_flag_n,
  output logic                   retransmit_active,
  output logic [ffr_pkg::DW-1:0] read_data,
  output logic [ffr_pkg::OW-1:0] empty_offset,
  output logic [ffr_pkg::OW-1:0] full_offset
);
  import ffr_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and port clock edges
  // ----------------------------------------------------------------
  localparam int unsigned WSW = DW + 10;
  localparam int unsigned RSW = 7;

  logic [WSW-1:0] ws_s;
  logic [RSW-1:0] rs_s;
  logic [DW-1:0]  w_data_s;
  logic           w_clk_s, w_sel_n_s, w_dir_s, w_stb_s, w_mail_s, w_rst_n_s, w_sen_n_s, w_sbit_s;
  logic [1:0]     w_mode_s;
  logic           r_clk_s, r_sel_n_s, r_dir_s, r_stb_s, r_mail_s, r_rtm_s, r_rfm_s;
  logic           w_clk_prev_q, r_clk_prev_q;

  ffr_sync #(.W(WSW)) u_wsync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pin_in   ({write_port_clock, write_side_select_n, write_side_direction, write_side_strobe,
                write_side_mail_sel, fifo_reset_n, serial_offset_en_n, serial_offset_bit,
                offset_mode, write_data}),
    .sync_q   (ws_s)
  );

  ffr_sync #(.W(RSW)) u_rsync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pin_in   ({read_port_clock, read_side_select_n, read_side_direction, read_side_strobe,
                read_side_mail_sel, replay_mode_in, replay_from_mark_in}),
    .sync_q   (rs_s)
  );

  assign {w_clk_s, w_sel_n_s, w_dir_s, w_stb_s, w_mail_s, w_rst_n_s, w_sen_n_s, w_sbit_s,
          w_mode_s, w_data_s} = ws_s;
  assign {r_clk_s, r_sel_n_s, r_dir_s, r_stb_s, r_mail_s, r_rtm_s, r_rfm_s} = rs_s;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      w_clk_prev_q <= 1'b0;
      r_clk_prev_q <= 1'b0;
    end else begin
      // No false edge from a port clock already high as a reset ends
      w_clk_prev_q <= w_clk_s | ~w_rst_n_s;
      r_clk_prev_q <= r_clk_s | ~w_rst_n_s;
    end
  end

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  logic          wr_edge, rd_edge, fifo_rst;
  logic          wr_req, wr_accept, rd_req;
  logic          replay, load, enter_rtm, exit_rtm;
  logic [PW-1:0] wptr_q, rptr_q, shadow_q, wbase, wfill_n, rptr_n;
  logic [AW-1:0] load_addr;
  logic          space_now, below_full_now, avail_now, above_empty_now;
  ffr_prog_e     prog_q;
  logic [1:0]    mark_cnt_q;
  logic          av_st1_q, av_st2_q, ws_st1_q, af_st1_q, ae_st1_q, load_pend_q;
  logic [DW-1:0] mem_rd;
  logic [SCW-1:0] scnt_q;

  assign wr_edge  = w_clk_s & ~w_clk_prev_q;
  assign rd_edge  = r_clk_s & ~r_clk_prev_q;
  assign fifo_rst = ~w_rst_n_s;

  assign wr_req    = wr_edge & ~w_sel_n_s & w_dir_s & w_stb_s & ~w_mail_s;  // [R24]
  assign wr_accept = wr_req & write_space_flag;                              // [R01]
  assign rd_req    = rd_edge & ~r_sel_n_s & r_dir_s & r_stb_s & ~r_mail_s;  // [R25]

  // ----------------------------------------------------------------
  // Write side comparators
  // ----------------------------------------------------------------
  assign wbase          = retransmit_active ? shadow_q : rptr_q;             // [R17] [R20]
  assign wfill_n        = ffr_fill(wptr_q, wbase) + {{(PW-1){1'b0}}, wr_accept};
  assign space_now      = wfill_n < DEPTH;                                   // [R02] [R18]
  assign below_full_now = wfill_n < (DEPTH - {1'b0, full_offset});           // [R09] [R21]

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wptr_q <= '0;
    end else if (fifo_rst) begin
      wptr_q <= '0;
    end else if (wr_accept) begin
      wptr_q <= ffr_inc(wptr_q);                                             // [R02]
    end
  end

  // Falls on the filling write, rises two write edges after space appears
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ws_st1_q         <= 1'b0;
      write_space_flag <= 1'b0;
    end else if (fifo_rst) begin
      ws_st1_q         <= 1'b0;
      write_space_flag <= 1'b0;
    end else if (wr_edge) begin
      ws_st1_q         <= space_now;                                         // [R04]
      write_space_flag <= space_now & ws_st1_q & (prog_q == PRG_DONE);       // [R03] [R26]
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      af_st1_q         <= 1'b0;
      near_full_flag_n <= 1'b0;
    end else if (fifo_rst) begin
      af_st1_q         <= 1'b0;
      near_full_flag_n <= 1'b0;
    end else if (wr_edge) begin
      af_st1_q         <= below_full_now;                                    // [R11]
      near_full_flag_n <= below_full_now & af_st1_q;                         // [R09] [R10] [R20]
    end
  end

  // ----------------------------------------------------------------
  // Offset registers and their loading
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prog_q       <= PRG_DONE;
      scnt_q       <= '0;
      empty_offset <= OFFSET_PRESET;
      full_offset  <= OFFSET_PRESET;
    end else if (fifo_rst) begin
      scnt_q       <= '0;
      empty_offset <= OFFSET_PRESET;                                         // [R08]
      full_offset  <= OFFSET_PRESET;
      unique case (w_mode_s)
        MODE_PORT:   prog_q <= PRG_PORT_X;
        MODE_SERIAL: prog_q <= PRG_SERIAL;
        default:     prog_q <= PRG_DONE;
      endcase
    end else if (wr_edge) begin
      unique case (prog_q)
        PRG_PORT_X: begin
          if (wr_req) begin
            empty_offset <= w_data_s[OW-1:0];                                // [R08]
            prog_q       <= PRG_PORT_Y;
          end
        end
        PRG_PORT_Y: begin
          if (wr_req) begin
            full_offset <= w_data_s[OW-1:0];
            prog_q      <= PRG_DONE;
          end
        end
        PRG_SERIAL: begin
          if (!w_sen_n_s) begin
            {empty_offset, full_offset} <= {empty_offset[OW-2:0], full_offset, w_sbit_s};  // [R08]
            scnt_q <= scnt_q + 5'h01;
            if (scnt_q == SERIAL_LAST) begin
              prog_q <= PRG_DONE;                                            // [R26]
            end
          end
        end
        PRG_DONE: begin
          prog_q <= PRG_DONE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read side: pointers, output register, retransmit
  // ----------------------------------------------------------------
  assign avail_now = ffr_fill(wptr_q, rptr_q) != '0;
  assign replay    = rd_edge & retransmit_active & r_rtm_s & r_rfm_s
                     & (mark_cnt_q == MARK_READS);                          // [R14]
  assign load      = ~replay & avail_now & av_st2_q & (~read_valid_flag | rd_req);  // [R23]
  assign enter_rtm = rd_edge & ~retransmit_active & r_rtm_s & read_valid_flag;      // [R12]
  assign exit_rtm  = rd_edge & retransmit_active & ~r_rtm_s;                        // [R13]
  assign load_addr = replay ? shadow_q[AW-1:0] : rptr_q[AW-1:0];

  always_comb begin
    rptr_n = rptr_q;
    if (replay) begin
      rptr_n = ffr_inc(shadow_q);                                            // [R19]
    end else if (rd_edge && load) begin
      rptr_n = ffr_inc(rptr_q);
    end
  end

  assign above_empty_now = ffr_fill(wptr_q, rptr_n) > {1'b0, empty_offset};  // [R05]

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rptr_q <= '0;
    end else if (fifo_rst) begin
      rptr_q <= '0;
    end else begin
      rptr_q <= rptr_n;                                                      // [R17]
    end
  end

  // Write seen by the read side after two read edges, loaded on the third
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      av_st1_q        <= 1'b0;
      av_st2_q        <= 1'b0;
      read_valid_flag <= 1'b0;
    end else if (fifo_rst) begin
      av_st1_q        <= 1'b0;
      av_st2_q        <= 1'b0;
      read_valid_flag <= 1'b0;
    end else if (rd_edge) begin
      av_st1_q <= avail_now;
      av_st2_q <= avail_now & av_st1_q;
      if (replay || load) begin
        read_valid_flag <= 1'b1;                                             // [R19] [R23]
      end else if (rd_req) begin
        read_valid_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ae_st1_q          <= 1'b0;
      near_empty_flag_n <= 1'b0;
    end else if (fifo_rst) begin
      ae_st1_q          <= 1'b0;
      near_empty_flag_n <= 1'b0;
    end else if (rd_edge) begin
      ae_st1_q          <= above_empty_now;                                  // [R07]
      near_empty_flag_n <= above_empty_now & ae_st1_q;                       // [R05] [R06] [R19]
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      retransmit_active <= 1'b0;
      shadow_q          <= '0;
    end else if (fifo_rst) begin
      retransmit_active <= 1'b0;
      shadow_q          <= '0;
    end else if (enter_rtm) begin
      retransmit_active <= 1'b1;
      shadow_q          <= rptr_q - PTR_ONE;                                 // [R12] [R17]
    end else if (exit_rtm) begin
      retransmit_active <= 1'b0;                                             // [R13] [R16]
    end
  end

  // Reads past the marked word, saturating
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mark_cnt_q <= '0;
    end else if (fifo_rst || enter_rtm || replay) begin
      mark_cnt_q <= '0;
    end else if (rd_edge && load && read_valid_flag && mark_cnt_q != MARK_READS) begin
      mark_cnt_q <= mark_cnt_q + 2'h1;                                       // [R14] [R15]
    end
  end

  // ----------------------------------------------------------------
  // Storage and output register
  // ----------------------------------------------------------------
  ffr_mem u_mem (
    .core_clk  (core_clk),
    .wr_en     (wr_accept),
    .wr_addr   (wptr_q[AW-1:0]),
    .wr_data   (w_data_s),
    .rd_addr   (load_addr),
    .rd_data_q (mem_rd)
  );                                                                         // [R22]

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      load_pend_q <= 1'b0;
      read_data   <= '0;
    end else begin
      load_pend_q <= replay | (rd_edge & load);
      if (load_pend_q) begin
        read_data <= mem_rd;                                                 // [R23]
      end
    end
  end
endmodule : ffr_top

// file: design/ffr_pkg.sv
// Constants, types and behaviour summary for the FIFO flag and retransmit block
// Function
// R01: Write-space flag high means a free location; low ignores every FIFO write.
// R02: Write pointer advances per accepted write; flag tracks full distance comparator.
// R03: Freed location raises write-space flag on second write-clock edge after the read.
// R04: Write-clock edge too close to the read defers first synchronising cycle.
// R05: Near-empty flag low at X or fewer words; output register word counts read.
// R06: Near-empty flag rises on second read-clock edge after write reaching X+1.
// R07: Read-clock edge too close to filling write defers first synchronising cycle.
// R08: Offsets X and Y held in registers: preset, port written or serially loaded.
// R09: Near-full flag low at 1024-Y words or more, high at 1024-(Y+1) or fewer.
// R10: Near-full flag rises on second write-clock edge after the reducing read.
// R11: Write-clock edge too close to reducing read defers first synchronising cycle.
// R12: Retransmit entered on read edge with replay mode and read-valid high.
// R13: Retransmit persists until a read edge samples replay mode low.
// R14: After two reads past mark, replay-from-mark reloads first retransmit word.
// R15: Reader uses retransmit sequences of at least three words.
// R16: Reader holds replay-from-mark low on the edge ending retransmit.
// R17: Retransmit keeps current and frozen shadow read pointers for different flags.
// R18: In retransmit, write-space flag falls on 1024th write after the mark.
// R19: Replay loads shadow into current pointer; read-valid at once, near-empty lags.
// R20: Leaving retransmit switches write flags to current pointer via two-edge sync.
// R21: In retransmit, near-full falls at 1024-Y words counted from the mark.
// R22: Storage of 1024 words by 36 bits, pointers one bit wider.
// R23: Read-valid high means new word in output register; low ignores reads.
// R24: FIFO write needs select low, mail low, direction, strobe and space high.
// R25: FIFO read needs select low, mail low, direction, strobe and read-valid high.
// R26: Serial offset load holds write-space low; rises next write edge after last bit.
package ffr_pkg;
  localparam int unsigned DW    = 36;
  localparam int unsigned AW    = 10;
  localparam int unsigned PW    = AW + 1;
  localparam int unsigned OW    = 10;
  localparam int unsigned SBITS = 2 * OW;
  localparam int unsigned SCW   = 5;

  localparam logic [PW-1:0]  DEPTH         = 11'h400;
  localparam logic [PW-1:0]  PTR_ONE       = 11'h001;
  localparam logic [OW-1:0]  OFFSET_PRESET = 10'h008;
  localparam logic [SCW-1:0] SERIAL_LAST   = 5'h13;
  localparam logic [1:0]     MODE_PRESET   = 2'h0;
  localparam logic [1:0]     MODE_PORT     = 2'h1;
  localparam logic [1:0]     MODE_SERIAL   = 2'h2;
  localparam logic [1:0]     MARK_READS    = 2'h2;

  typedef enum logic [1:0] {PRG_DONE, PRG_PORT_X, PRG_PORT_Y, PRG_SERIAL} ffr_prog_e;

  // Words between two pointers
  function automatic logic [PW-1:0] ffr_fill(input logic [PW-1:0] a, input logic [PW-1:0] b);
    return a - b;
  endfunction : ffr_fill

  // Pointer plus one
  function automatic logic [PW-1:0] ffr_inc(input logic [PW-1:0] p);
    return p + PTR_ONE;
  endfunction : ffr_inc
endpackage : ffr_pkg

// file: design/ffr_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module ffr_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // Pins and synchronised copy
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sync_q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end
endmodule : ffr_sync

// file: design/ffr_mem.sv
// Storage array with registered read data
`timescale 1ns/1ps
module ffr_mem
  import ffr_pkg::*;
(
  // Clock
  input  wire logic          core_clk,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // Read port
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data_q
);
  logic [DW-1:0] mem_q [2**AW];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
    rd_data_q <= mem_q[rd_addr];
  end
endmodule : ffr_mem

// file: tb/ffr_checker.sv
// Pin level timing checks for the flag and retransmit block
`timescale 1ns/1ps
module ffr_checker (
  // Clock and reset
  input wire logic                   core_clk,
  input wire logic                   rstn,
  // Port clocks and offset control
  input wire logic                   write_port_clock,
  input wire logic                   read_port_clock,
  input wire logic                   fifo_reset_n,
  input wire logic [1:0]             offset_mode,
  // Flags and data
  input wire logic                   write_space_flag,
  input wire logic                   near_full_flag_n,
  input wire logic                   read_valid_flag,
  input wire logic                   near_empty_flag_n,
  input wire logic                   retransmit_active,
  input wire logic [ffr_pkg::DW-1:0] read_data,
  input wire logic [ffr_pkg::OW-1:0] empty_offset,
  input wire logic [ffr_pkg::OW-1:0] full_offset
);
  import ffr_pkg::*;
  logic       wclk_q, rclk_q;
  logic [3:0] wcnt_q, rcnt_q;
  // --------------------------------
  // Core clocks since each port rise
  // --------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wclk_q <= 1'h0;
      wcnt_q <= 4'hF;
    end else begin
      wclk_q <= write_port_clock;
      wcnt_q <= (write_port_clock && !wclk_q) ? 4'h0 : ((wcnt_q == 4'hF) ? wcnt_q : wcnt_q + 4'h1);
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rclk_q <= 1'h0;
      rcnt_q <= 4'hF;
    end else begin
      rclk_q <= read_port_clock;
      rcnt_q <= (read_port_clock && !rclk_q) ? 4'h0 : ((rcnt_q == 4'hF) ? rcnt_q : rcnt_q + 4'h1);
    end
  end
  // --------------------------------
  // Assertions
  // --------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn || !fifo_reset_n);
  a_space_wclk: assert property ($changed(write_space_flag) |-> wcnt_q inside {[1:6]})
    else $error("write space flag moved away from a write event");
  a_nfull_wclk: assert property ($changed(near_full_flag_n) |-> wcnt_q inside {[1:6]})
    else $error("near full flag moved away from a write event");
  a_valid_rclk: assert property ($changed(read_valid_flag) |-> rcnt_q inside {[1:7]})
    else $error("read valid flag moved away from a read event");
  a_nempty_rclk: assert property ($changed(near_empty_flag_n) |-> rcnt_q inside {[1:7]})
    else $error("near empty flag moved away from a read event");
  a_data_rclk: assert property ($changed(read_data) |-> rcnt_q inside {[1:8]})
    else $error("read data moved away from a read event");
  a_mode_rclk: assert property ($changed(retransmit_active) |-> rcnt_q inside {[1:7]})
    else $error("retransmit mode moved away from a read event");
  a_data_hold: assert property (!read_valid_flag && !$past(read_valid_flag) |-> $stable(read_data))
    else $error("read data changed while no word was valid");
  a_mode_valid: assert property ($rose(retransmit_active) |-> $past(read_valid_flag))
    else $error("retransmit entered without a valid word");
  a_full_link: assert property ($fell(write_space_flag) |-> !near_full_flag_n)
    else $error("full without near full");
  a_offset_hold: assert property (fifo_reset_n && offset_mode == MODE_PRESET
    |-> $stable(empty_offset) && $stable(full_offset))
    else $error("offsets changed outside programming");
endmodule : ffr_checker

bind ffr_top ffr_checker ffr_checker_inst (.core_clk(core_clk), .rstn(rstn),
  .write_port_clock(write_port_clock), .read_port_clock(read_port_clock), .fifo_reset_n(fifo_reset_n),
  .offset_mode(offset_mode), .write_space_flag(write_space_flag), .near_full_flag_n(near_full_flag_n),
  .read_valid_flag(read_valid_flag), .near_empty_flag_n(near_empty_flag_n),
  .retransmit_active(retransmit_active), .read_data(read_data), .empty_offset(empty_offset),
  .full_offset(full_offset));

// file: tb/ffr_port_partner.sv
// Free-running port clocks of the parties at both ports
`timescale 1ns/1ps
module ffr_port_partner #(
  parameter int unsigned WHALF = 700,
  parameter int unsigned RHALF = 800
) (
  // Port clocks
  output logic write_port_clock,
  output logic read_port_clock
);
  initial begin
    write_port_clock = 1'h0;
    forever #(WHALF) write_port_clock = ~write_port_clock;
  end
  // Offset start keeps the two ports unrelated in phase
  initial begin
    read_port_clock = 1'h0;
    #37;
    forever #(RHALF) read_port_clock = ~read_port_clock;
  end
endmodule : ffr_port_partner

// file: tb/tb_ffr_top.sv
// Self-checking bench for the flag and retransmit block
`timescale 1ns/1ps
module tb_ffr_top;
  import ffr_pkg::*;
  localparam logic [3:0] GOOD = 4'h6;
  localparam logic [3:0] IDLE = 4'h8;
  logic          core_clk, rstn, wclk, rclk, w_sel_n, w_dir, w_stb, w_mb, r_sel_n, r_dir, r_stb, r_mb;
  logic          rp_mode, rp_mark, sp_f, nf_n, rv_f, ne_n, rt_act, vm, f_rst_n, s_en_n, s_bit;
  logic [1:0]    o_mode;
  logic [DW-1:0] w_dat, rdat;
  logic [OW-1:0] xoff, yoff;
  logic [DW-1:0] w[$];
  logic [3:0]    bad [4] = '{4'hE, 4'h2, 4'h4, 4'h7};
  int            oi, mark, i, k, err_count, cmp_count;
  ffr_port_partner ffr_port_partner_inst (.write_port_clock(wclk), .read_port_clock(rclk));
  ffr_top ffr_top_inst (.core_clk(core_clk), .rstn(rstn), .write_port_clock(wclk),
    .write_side_select_n(w_sel_n), .write_side_direction(w_dir), .write_side_strobe(w_stb),
    .write_side_mail_sel(w_mb), .write_data(w_dat), .fifo_reset_n(f_rst_n), .offset_mode(o_mode),
    .serial_offset_en_n(s_en_n), .serial_offset_bit(s_bit), .read_port_clock(rclk),
    .read_side_select_n(r_sel_n), .read_side_direction(r_dir), .read_side_strobe(r_stb),
    .read_side_mail_sel(r_mb), .replay_mode_in(rp_mode), .replay_from_mark_in(rp_mark),
    .write_space_flag(sp_f), .near_full_flag_n(nf_n), .read_valid_flag(rv_f), .near_empty_flag_n(ne_n),
    .retransmit_active(rt_act), .read_data(rdat), .empty_offset(xoff), .full_offset(yoff));
  // --------------------------------
  // Helpers
  // --------------------------------
  function automatic int fill();
    return w.size() - oi - 1;
  endfunction : fill
  task automatic ck(input string nm, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : ck
  task automatic close_out();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  // Pins set after a port clock fall, released after its rise
  task automatic wr(input logic [3:0] q);
    @(negedge wclk);
    @(negedge core_clk);
    {w_sel_n, w_dir, w_stb, w_mb} = q;
    w_dat = DW'({$urandom, $urandom});
    @(posedge wclk);
    if (sp_f && q == GOOD) w.push_back(w_dat);
    repeat (5) @(negedge core_clk);
    {w_sel_n, w_dir, w_stb, w_mb} = IDLE;
  endtask : wr
  task automatic rd(input logic [3:0] q, input logic m, input logic f);
    @(negedge rclk);
    @(negedge core_clk);
    {r_sel_n, r_dir, r_stb, r_mb} = q;
    rp_mode = m;
    rp_mark = f;
    @(posedge rclk);
    if (m && rv_f && !rt_act) mark = oi;
    if (m && f && rt_act && oi >= mark + 2) begin
      oi = mark;
      vm = 1'h1;
    end else if (rv_f && q == GOOD) begin
      if (oi + 1 < w.size()) oi++;
      else vm = 1'h0;
    end
    repeat (5) @(negedge core_clk);
    {r_sel_n, r_dir, r_stb, r_mb} = IDLE;
  endtask : rd
  task automatic fifo_clear(input logic [1:0] md);
    @(negedge core_clk);
    {f_rst_n, o_mode} = {1'h0, md};
    repeat (5) @(negedge core_clk);
    f_rst_n = 1'h1;
  endtask : fifo_clear
  task automatic settle(input logic m);
    repeat (4) rd(IDLE, m, 1'h0);
    if (!vm && oi + 1 < w.size()) begin
      oi++;
      vm = 1'h1;
    end
    ck("read valid", rv_f, vm);
    ck("read data", rdat, w[oi]);
    ck("near empty", ne_n, fill() > OFFSET_PRESET);
    ck("retransmit", rt_act, m);
  endtask : settle
  // --------------------------------
  // Clock, watchdog and tests
  // --------------------------------
  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    #4000000;
    err_count++;
    close_out();
  end
  initial begin
    {rstn, w_sel_n, w_dir, w_stb, w_mb, r_sel_n, r_dir, r_stb, r_mb} = 9'h088;
    {f_rst_n, s_en_n, s_bit, o_mode} = {3'h6, MODE_PRESET};
    {rp_mode, rp_mark, vm, w_dat} = '0;
    {oi, mark, err_count, cmp_count} = {-32'sd1, 96'h0};
    void'($urandom(73388));
    repeat (12) @(negedge core_clk);
    ck("x offset", xoff, OFFSET_PRESET);
    ck("y offset", yoff, OFFSET_PRESET);
    ck("space in reset", sp_f, 1'h0);
    rstn = 1'h1;
    for (i = 0; i < 20 && sp_f !== 1'h1; i++) @(negedge wclk);
    ck("space after reset", sp_f, 1'h1);
    $display("Test reset done");
    for (k = 0; k < 4; k++) wr(bad[k]);
    for (i = 0; i < 9; i++) wr(GOOD);
    wr(IDLE);
    settle(1'h0);
    wr(GOOD);
    ck("near empty lag", ne_n, 1'h0);
    wr(IDLE);
    settle(1'h0);
    for (k = 0; k < 4; k++) rd(bad[k], 1'h0, 1'h0);
    settle(1'h0);
    for (i = 0; i < 3; i++) rd(GOOD, 1'h0, 1'h0);
    settle(1'h0);
    $display("Test qualifiers done");
    rd(IDLE, 1'h1, 1'h0);
    settle(1'h1);
    for (k = 0; k < 2; k++) begin
      for (i = 0; i < 3; i++) rd(GOOD, 1'h1, 1'h0);
      rd(IDLE, 1'h1, 1'h1);
      settle(1'h1);
      ck("mark word", rdat, w[mark]);
    end
    rd(IDLE, 1'h0, 1'h0);
    settle(1'h0);
    $display("Test retransmit done");
    for (i = 0; i < 1100 && sp_f === 1'h1; i++) begin
      wr(GOOD);
      ck("near full", nf_n, fill() <= DEPTH - OFFSET_PRESET - 1);
    end
    ck("words when full", fill(), DEPTH);
    wr(GOOD);
    wr(IDLE);
    ck("space when full", sp_f, 1'h0);
    rd(GOOD, 1'h0, 1'h0);
    ck("space lag", sp_f, 1'h0);
    repeat (3) wr(IDLE);
    ck("space back", sp_f, 1'h1);
    for (i = 0; i < 8; i++) rd(GOOD, 1'h0, 1'h0);
    ck("near full lag", nf_n, 1'h0);
    repeat (3) wr(IDLE);
    ck("near full back", nf_n, 1'h1);
    settle(1'h0);
    $display("Test full done");
    fifo_clear(MODE_PORT);
    wr(GOOD);
    ck("x from port", xoff, w_dat[OW-1:0]);
    wr(GOOD);
    ck("y from port", yoff, w_dat[OW-1:0]);
    ck("space while programming", sp_f, 1'h0);
    wr(IDLE);
    ck("space after program", sp_f, 1'h1);
    fifo_clear(MODE_SERIAL);
    w_dat = DW'({$urandom, $urandom});
    for (k = 0; k < SBITS; k++) begin
      @(negedge wclk);
      @(negedge core_clk);
      {s_en_n, s_bit} = {1'h0, w_dat[SBITS-1-k]};
      @(posedge wclk);
    end
    @(negedge wclk);
    @(negedge core_clk);
    s_en_n = 1'h1;
    ck("space during serial", sp_f, 1'h0);
    ck("x serial", xoff, w_dat[SBITS-1:OW]);
    ck("y serial", yoff, w_dat[OW-1:0]);
    wr(IDLE);
    ck("space after serial", sp_f, 1'h1);
    $display("Test program done");
    close_out();
  end
endmodule : tb_ffr_top
